// ---- hdl/pic_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module pic_ctrl (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // configuration and system reset
  input wire logic full_variant_in,
  input wire logic sys_reset_in,
  // microprogram side
  input wire logic op_valid_in,
  input wire pic_pkg::pic_op_s op_in,
  input wire logic instr_done_in,
  input wire logic interruptible_in,
  output logic op_busy_out,
  output logic cc_keep_out,
  // interrupt entry
  output logic take_out,
  output logic [pic_pkg::LVL_W-1:0] take_level_out,
  output logic [pic_pkg::ADDR_W-1:0] take_loc_out,
  output logic ivec_fetch_out,
  output logic [pic_pkg::ADDR_W-1:0] ivec_addr_out,
  // peripheral controllers
  input wire logic [pic_pkg::NUM_LEVELS-1:0] req_in,
  input wire logic [pic_pkg::UNIT_W-1:0] unit_addr_in,
  output logic [pic_pkg::NUM_LEVELS-1:0] ack_out,
  output logic dev_clear_out,
  // status
  output pic_pkg::pic_status_s status_out
);
  typedef enum logic [2:0] {RST_IDLE, RST_OPEN, RST_ACK, RST_SETTLE, RST_CLEAR} pic_rst_e;

  pic_rst_e rst_state;
  pic_rst_e next_rst_state;
  pic_pkg::pic_lvl_e lvl [pic_pkg::NUM_LEVELS];
  logic [pic_pkg::NUM_LEVELS-1:0] armed;
  logic [pic_pkg::NUM_LEVELS-1:0] sel;
  logic [pic_pkg::NUM_LEVELS-1:0] lvl_wait;
  logic [pic_pkg::NUM_LEVELS-1:0] lvl_act;
  logic [pic_pkg::NUM_LEVELS-1:0] lvl_busy;
  logic [pic_pkg::NUM_LEVELS-1:0] op_mask;
  logic [pic_pkg::NUM_LEVELS-1:0] reset_now;
  logic [pic_pkg::NUM_LEVELS-1:0] open_mask;
  logic [pic_pkg::NUM_LEVELS-1:0] loop_ack;
  logic [pic_pkg::NUM_LEVELS-1:0] take_hit;
  logic [pic_pkg::NUM_LEVELS-1:0] rel_hit;
  logic [2:0] settle_cnt;
  logic [1:0] inhib_cnt;
  logic inhibit;
  logic take_ok;
  logic take_fire;
  logic busy_any;
  logic [pic_pkg::LVL_W-1:0] take_lvl;
  logic [pic_pkg::LVL_W-1:0] busy_top;
  logic vec_ready;
  logic ivec_fire;
  logic release_now;
  logic op_reset;
  logic op_arm;
  logic op_disarm;
  logic op_ivec;
  logic op_inhib;

  assign op_mask = op_in.operand[pic_pkg::MASK_LSB +: pic_pkg::NUM_LEVELS];
  assign op_reset = op_valid_in && op_in.op == pic_pkg::LEVEL_RESET_OP;
  assign op_arm = op_valid_in && op_in.op == pic_pkg::LEVEL_ARM_OP;
  assign op_disarm = op_valid_in && op_in.op == pic_pkg::LEVEL_DISARM_OP;
  assign op_ivec = op_valid_in && op_in.op == pic_pkg::INDIRECT_VECTOR_OP;
  assign op_busy_out = rst_state != RST_IDLE;
  assign cc_keep_out = op_reset || op_arm || op_disarm || op_ivec;

  // full-variant level reset sequence
  always_comb begin
    next_rst_state = rst_state;
    unique case (rst_state)
      RST_IDLE: if (op_reset && full_variant_in) next_rst_state = RST_OPEN;
      RST_OPEN: next_rst_state = RST_ACK;
      RST_ACK: next_rst_state = RST_SETTLE;
      RST_SETTLE: begin
        // a controller that re-raises within the settle time forces another pass
        if (settle_cnt == pic_pkg::SETTLE_CYC) begin
          next_rst_state = |(sel & (lvl_wait | req_in)) ? RST_OPEN : RST_CLEAR;
        end
      end
      RST_CLEAR: next_rst_state = RST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_state <= RST_IDLE;
    end else if (sys_reset_in) begin
      rst_state <= RST_IDLE;
    end else begin
      rst_state <= next_rst_state;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sel <= '0;
    end else if (rst_state == RST_IDLE && op_reset) begin
      sel <= op_mask;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      settle_cnt <= '0;
    end else if (rst_state == RST_SETTLE) begin
      settle_cnt <= settle_cnt + 3'h1;
    end else begin
      settle_cnt <= 3'h1;
    end
  end

  // which levels go inactive this cycle
  always_comb begin
    reset_now = '0;
    if (rst_state == RST_IDLE && op_reset && !full_variant_in) begin
      reset_now = op_mask;
    end
    if (rst_state == RST_CLEAR) begin
      reset_now = sel | lvl_act | (lvl_wait & armed);
    end
  end
  assign open_mask = (rst_state == RST_OPEN) ? (sel & lvl_wait) : '0;
  assign loop_ack = (rst_state == RST_ACK) ? (sel & lvl_act) : '0;

  // chain load and take both wait for the instruction after an inhibiting one
  assign op_inhib = op_valid_in && (op_in.op == pic_pkg::REMOTE_RUN_OP || op_ivec
    || op_in.op == pic_pkg::CALL_SAVE_OP || op_in.op == pic_pkg::BRANCH_LINK_OP
    || op_arm || (op_reset && full_variant_in));
  assign inhibit = inhib_cnt != 2'h0;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      inhib_cnt <= '0;
    end else if (sys_reset_in) begin
      inhib_cnt <= '0;
    end else if (op_inhib && instr_done_in) begin
      // the op's own completion already counts as the first of the two
      inhib_cnt <= pic_pkg::INHIB_SPAN - 2'h1;
    end else if (op_inhib) begin
      inhib_cnt <= pic_pkg::INHIB_SPAN;
    end else if (instr_done_in && inhibit) begin
      inhib_cnt <= inhib_cnt - 2'h1;
    end
  end

  pic_prio_sel u_prio (
    .active_in(lvl_act),
    .busy_in(lvl_busy),
    .take_ok_out(take_ok),
    .take_lvl_out(take_lvl),
    .busy_any_out(busy_any),
    .busy_top_out(busy_top)
  );

  assign take_fire = interruptible_in && take_ok && !inhibit && rst_state == RST_IDLE;
  // level cleared by return-release or by a vectored count or transfer
  assign release_now = busy_any && op_valid_in && (op_in.op == pic_pkg::RETURN_RELEASE_OP
    || (vec_ready && (op_in.op == pic_pkg::COUNT_INCREMENT_OP
      || op_in.op == pic_pkg::IO_TRANSFER_OP)));
  assign ivec_fire = op_ivec && vec_ready
    && op_in.exec_loc == pic_pkg::ADDR_W'(take_level_out * pic_pkg::LOC_STRIDE);

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vec_ready <= 1'b0;
    end else if (sys_reset_in) begin
      vec_ready <= 1'b0;
    end else if (take_fire) begin
      vec_ready <= 1'b1;
    end else if (op_valid_in && !ivec_fire) begin
      vec_ready <= 1'b0;
    end
  end

  // per-level state; a reset busy level loses its flag but its routine keeps running
  for (genvar i = 0; i < pic_pkg::NUM_LEVELS; i++) begin : g_lvl
    assign take_hit[i] = take_fire && take_lvl == 3'(i);
    assign rel_hit[i] = release_now && busy_top == 3'(i);
    assign lvl_wait[i] = lvl[i] == pic_pkg::LVL_WAITING;
    assign lvl_act[i] = lvl[i] == pic_pkg::LVL_ACTIVE;
    assign lvl_busy[i] = lvl[i] == pic_pkg::LVL_BUSY;
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        lvl[i] <= pic_pkg::LVL_INACTIVE;
      end else if (sys_reset_in) begin
        lvl[i] <= pic_pkg::LVL_INACTIVE;
      end else if (reset_now[i] || loop_ack[i]) begin
        lvl[i] <= pic_pkg::LVL_INACTIVE;
      end else if (take_hit[i]) begin
        lvl[i] <= pic_pkg::LVL_BUSY;
      end else if (rel_hit[i]) begin
        lvl[i] <= pic_pkg::LVL_INACTIVE;
      end else begin
        unique case (lvl[i])
          pic_pkg::LVL_INACTIVE: begin
            // a request that system reset is clearing is not recorded again
            if (req_in[i] && !dev_clear_out) begin
              lvl[i] <= pic_pkg::LVL_WAITING;
            end
          end
          pic_pkg::LVL_WAITING: begin
            if ((armed[i] && !inhibit) || open_mask[i]) begin
              lvl[i] <= pic_pkg::LVL_ACTIVE;
            end
          end
          pic_pkg::LVL_ACTIVE: lvl[i] <= pic_pkg::LVL_ACTIVE;
          pic_pkg::LVL_BUSY: lvl[i] <= pic_pkg::LVL_BUSY;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      armed <= pic_pkg::ARMED_RST;
    end else if (sys_reset_in) begin
      armed <= pic_pkg::ARMED_RST;
    end else if (rst_state == RST_CLEAR) begin
      armed <= armed | sel;
    end else if (op_arm) begin
      armed <= armed | op_mask;
    end else if (op_disarm) begin
      armed <= armed & ~op_mask;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_out <= '0;
      dev_clear_out <= 1'b0;
    end else begin
      ack_out <= loop_ack | take_hit;
      dev_clear_out <= sys_reset_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      take_out <= 1'b0;
      take_level_out <= '0;
      take_loc_out <= '0;
    end else begin
      take_out <= take_fire;
      if (take_fire) begin
        take_level_out <= take_lvl;
        take_loc_out <= pic_pkg::ADDR_W'(take_lvl * pic_pkg::LOC_STRIDE);
      end
    end
  end

  pic_ivec u_ivec (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .capture_in(take_fire),
    .unit_addr_in(unit_addr_in),
    .fire_in(ivec_fire),
    .loc_in(op_in.operand_location),
    .fetch_out(ivec_fetch_out),
    .fetch_addr_out(ivec_addr_out)
  );

  assign status_out = '{armed: armed, waiting: lvl_wait, active: lvl_act, busy: lvl_busy};

  a_sys_reset_all: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    sys_reset_in |=> armed == '0 && lvl_wait == '0 && lvl_act == '0 && lvl_busy == '0
      && dev_clear_out)
    else $error("system reset left level state");
  a_basic_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    op_reset && !full_variant_in && !sys_reset_in && rst_state == RST_IDLE
      |=> ((lvl_wait | lvl_act | lvl_busy) & $past(op_mask)) == '0)
    else $error("reset level not inactive");
  a_arm_mask: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    op_arm && !sys_reset_in && rst_state == RST_IDLE
      |=> (armed & $past(op_mask)) == $past(op_mask)
        && (armed & ~$past(op_mask)) == ($past(armed) & ~$past(op_mask)))
    else $error("arm mask misapplied");
  a_disarm_mask: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    op_disarm && !sys_reset_in && rst_state == RST_IDLE
      |=> (armed & $past(op_mask)) == '0
        && (armed & ~$past(op_mask)) == ($past(armed) & ~$past(op_mask)))
    else $error("disarm mask misapplied");
  a_inhibit_take: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    op_inhib && !sys_reset_in ##1 !instr_done_in |=> !take_out)
    else $error("interrupt taken while inhibited");
  a_prio_nest: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    take_fire |-> !(busy_any && take_lvl >= busy_top) && lvl_act[take_lvl])
    else $error("take does not outrank busy level");
  a_ivec_gate: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    op_ivec && !vec_ready |=> !ivec_fetch_out)
    else $error("indirect vector acted outside interrupt");
  a_full_rearm: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    rst_state == RST_CLEAR && !sys_reset_in |=> (armed & $past(sel)) == $past(sel)
      && lvl_act == '0)
    else $error("full reset left level disarmed or active");
  a_disarmed_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    rst_state == RST_IDLE |=> (lvl_act & ~$past(lvl_act) & ~$past(armed)) == '0)
    else $error("disarmed level went active");
  a_cc_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    op_arm || op_disarm || op_reset || op_ivec |-> cc_keep_out)
    else $error("condition codes not held");
  a_full_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    rst_state == RST_CLEAR && !sys_reset_in
      |=> (lvl_wait & $past(lvl_wait) & $past(armed)) == '0)
    else $error("full reset left armed level waiting");

  c_full_loop: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    rst_state == RST_SETTLE ##1 rst_state == RST_OPEN);
  c_preempt: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    take_fire && busy_any);
  c_ivec: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in) ivec_fire);
  c_basic_reset: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    op_reset && !full_variant_in);
  c_full_done: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    rst_state == RST_CLEAR);
endmodule
`default_nettype wire

// ---- hdl/pic_ivec.sv ----
`timescale 1ns/100ps
`default_nettype none
module pic_ivec (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // capture and fire
  input wire logic capture_in,
  input wire logic [pic_pkg::UNIT_W-1:0] unit_addr_in,
  input wire logic fire_in,
  input wire logic [pic_pkg::ADDR_W-1:0] loc_in,
  // fetch request
  output logic fetch_out,
  output logic [pic_pkg::ADDR_W-1:0] fetch_addr_out
);
  logic [pic_pkg::UNIT_W-1:0] unit;

  // unit address held from the take, the source may drop it once acknowledged
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      unit <= '0;
    end else if (capture_in) begin
      unit <= unit_addr_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fetch_out <= 1'b0;
      fetch_addr_out <= '0;
    end else begin
      fetch_out <= fire_in;
      if (fire_in) begin
        fetch_addr_out <= {loc_in[pic_pkg::ADDR_W-1:pic_pkg::UNIT_W], unit};
      end
    end
  end

  a_ivec_addr: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    fire_in |=> fetch_out && fetch_addr_out[pic_pkg::UNIT_W-1:0] == $past(unit)
      && fetch_addr_out[pic_pkg::ADDR_W-1:pic_pkg::UNIT_W]
        == $past(loc_in[pic_pkg::ADDR_W-1:pic_pkg::UNIT_W]))
    else $error("indirect fetch address wrong");
endmodule
`default_nettype wire

// ---- hdl/pic_pkg.sv ----
// Summary of operation
// - level reset returns each selected level to inactive, dropping any recorded request.
// - resetting a busy level does not abort the service work already running.
// - system reset resets and disarms all levels and clears device-held requests.
// - after listed instructions, no take or chain load until next instruction completes.
// - indirect vector acts only from the taken level's dedicated location.
// - indirect vector puts unit address in low six address bits and fetches there.
// - vectored count or transfer auto-clears the level; call-save needs return-release.
// - level reset takes its level mask from operand bits 16 to 23.
// - basic variant reset leaves controller requests pending; interrupts allowed at once.
// - full variant reset loops releasing and acknowledging requests, then clears states.
// - full variant reset leaves every selected level armed.
// - full variant reset clears all active levels and waiting of armed levels.
// - arm sets armed for each level with a one in the mask.
// - disarm clears armed for each level with a one in the mask.
// - interrupt control instructions leave the condition codes unchanged.
// - a disarmed level holds its request waiting until armed, then goes active; a full variant reset that selects it opens it while disarmed.
// - level 0 is highest; higher levels preempt lower busy ones, never the reverse.
// - each level is in exactly one of inactive, waiting, active or busy.
`default_nettype none
package pic_pkg;
  localparam int unsigned NUM_LEVELS = 8;
  localparam int unsigned LVL_W = 3;
  localparam int unsigned OPND_W = 24;
  localparam int unsigned MASK_LSB = 16;
  localparam int unsigned UNIT_W = 6;
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned LOC_STRIDE = 2;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SETTLE_NS = 100;
  localparam logic [2:0] SETTLE_CYC =
    3'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] INHIB_SPAN = 2'h2;
  localparam logic [7:0] ARMED_RST = 8'h00;

  typedef enum logic [3:0] {
    NO_OP, LEVEL_RESET_OP, LEVEL_ARM_OP, LEVEL_DISARM_OP, INDIRECT_VECTOR_OP,
    REMOTE_RUN_OP, CALL_SAVE_OP, BRANCH_LINK_OP, RETURN_RELEASE_OP,
    PLAIN_RETURN_OP, COUNT_INCREMENT_OP, IO_TRANSFER_OP, OTHER_OP
  } pic_op_e;

  typedef enum logic [1:0] {LVL_INACTIVE, LVL_WAITING, LVL_ACTIVE, LVL_BUSY} pic_lvl_e;

  typedef struct packed {
    pic_op_e op;
    logic [OPND_W-1:0] operand;
    logic [ADDR_W-1:0] operand_location;
    logic [ADDR_W-1:0] exec_loc;
  } pic_op_s;

  typedef struct packed {
    logic [NUM_LEVELS-1:0] armed;
    logic [NUM_LEVELS-1:0] waiting;
    logic [NUM_LEVELS-1:0] active;
    logic [NUM_LEVELS-1:0] busy;
  } pic_status_s;
endpackage
`default_nettype wire

// ---- hdl/pic_prio_sel.sv ----
`timescale 1ns/100ps
`default_nettype none
module pic_prio_sel (
  // level vectors
  input wire logic [pic_pkg::NUM_LEVELS-1:0] active_in,
  input wire logic [pic_pkg::NUM_LEVELS-1:0] busy_in,
  // selection
  output logic take_ok_out,
  output logic [pic_pkg::LVL_W-1:0] take_lvl_out,
  output logic busy_any_out,
  output logic [pic_pkg::LVL_W-1:0] busy_top_out
);
  logic act_any;

  // scan from lowest priority so level 0 ends up winning
  always_comb begin
    act_any = 1'b0;
    take_lvl_out = '0;
    busy_any_out = 1'b0;
    busy_top_out = '0;
    for (int i = pic_pkg::NUM_LEVELS - 1; i >= 0; i--) begin
      if (active_in[i]) begin
        act_any = 1'b1;
        take_lvl_out = 3'(i);
      end
      if (busy_in[i]) begin
        busy_any_out = 1'b1;
        busy_top_out = 3'(i);
      end
    end
    take_ok_out = act_any && (!busy_any_out || take_lvl_out < busy_top_out);
  end
endmodule
`default_nettype wire

// ---- tb/pic_periph_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pic_periph_model (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // bench commands
  input wire logic [7:0] raise_in,
  input wire logic [5:0] unit_in,
  // controller side
  input wire logic [7:0] ack_in,
  input wire logic dev_clear_in,
  output logic [7:0] req_out,
  output logic [5:0] unit_addr_out
);
  logic [5:0] unit;
  // request is a level, held until acknowledged
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      req_out <= 8'h00;
      unit <= 6'h00;
    end else if (dev_clear_in) begin
      req_out <= 8'h00;
    end else begin
      req_out <= (req_out & ~ack_in) | raise_in;
      if (|raise_in) begin
        unit <= unit_in;
      end
    end
  end
  // nobody drives the unit lines when idle: show the inverse, not the last value
  assign unit_addr_out = (|req_out) ? unit : ~unit;
endmodule
`default_nettype wire

// ---- tb/priority_interrupt_control_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_control_tb;
  logic clk_sys, rst_b, full_var, sys_reset, op_valid, instr_done, intr_ok;
  pic_pkg::pic_op_s op;
  pic_pkg::pic_status_s st;
  logic [7:0] raise, req, ack;
  logic [5:0] unit, unit_addr;
  logic op_busy, cc_keep, take, ivec_fetch, dev_clear;
  logic [2:0] take_level;
  logic [16:0] take_loc, ivec_addr;
  int err_total, n_compared, takes, t0;

  pic_ctrl u_pic_ctrl (.clk_sys_in(clk_sys), .rst_b_in(rst_b), .full_variant_in(full_var),
    .sys_reset_in(sys_reset), .op_valid_in(op_valid), .op_in(op), .instr_done_in(instr_done),
    .interruptible_in(intr_ok), .op_busy_out(op_busy), .cc_keep_out(cc_keep),
    .take_out(take), .take_level_out(take_level), .take_loc_out(take_loc),
    .ivec_fetch_out(ivec_fetch), .ivec_addr_out(ivec_addr), .req_in(req),
    .unit_addr_in(unit_addr), .ack_out(ack), .dev_clear_out(dev_clear), .status_out(st));
  pic_periph_model u_pic_periph_model (.clk_sys_in(clk_sys), .rst_b_in(rst_b),
    .raise_in(raise), .unit_in(unit), .ack_in(ack), .dev_clear_in(dev_clear),
    .req_out(req), .unit_addr_out(unit_addr));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // counted on the edge that ends the pulse, so no race with the update
  always @(posedge clk_sys) begin
    if (take === 1'b1) takes++;
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic do_op(input pic_pkg::pic_op_e o, input logic [7:0] m,
                       input logic [16:0] loc, input logic [16:0] ex);
    // one idle edge first, so op_valid never drops and rises in one time step
    @(negedge clk_sys);
    op = '{o, {m, 16'h0000}, loc, ex};
    op_valid = 1'b1;
    instr_done = 1'b1;
    #1;
    chk(cc_keep, o inside {pic_pkg::LEVEL_RESET_OP, pic_pkg::LEVEL_ARM_OP,
      pic_pkg::LEVEL_DISARM_OP, pic_pkg::INDIRECT_VECTOR_OP}, "cc keep");
    @(negedge clk_sys);
    op_valid = 1'b0;
    instr_done = 1'b0;
  endtask
  task automatic req_up(input logic [7:0] m, input logic [5:0] u);
    raise = m;
    unit = u;
    @(negedge clk_sys);
    raise = 8'h00;
  endtask
  task automatic wait_take(input logic [2:0] lvl);
    for (int i = 0; i < 20 && take !== 1'b1; i++) @(negedge clk_sys);
    chk(take, 1, "take");
    chk(take_level, lvl, "take level");
    chk(take_loc, {lvl, 1'b0}, "take loc");
    chk(ack[lvl], 1, "take ack");
  endtask

  task automatic t_arm();
    for (int i = 0; i < 8; i++) begin
      do_op(pic_pkg::LEVEL_ARM_OP, 8'h01 << i, 17'h0, 17'h0);
      chk(st.armed, (32'h2 << i) - 1, "armed walk");
    end
    do_op(pic_pkg::LEVEL_DISARM_OP, 8'h55, 17'h0, 17'h0);
    chk(st.armed, 8'haa, "disarm");
    do_op(pic_pkg::LEVEL_DISARM_OP, 8'hff, 17'h0, 17'h0);
    chk(st.armed, 8'h00, "disarm all");
  endtask
  task automatic t_wait_arm();
    req_up(8'h08, 6'h11);
    intr_ok = 1'b1;
    cyc(4);
    chk({st.waiting, st.active, st.busy}, {8'h08, 16'h0}, "held waiting");
    do_op(pic_pkg::LEVEL_ARM_OP, 8'h08, 17'h0, 17'h0);
    t0 = takes;
    cyc(4);
    chk(takes - t0, 0, "take under inhibit");
    do_op(pic_pkg::OTHER_OP, 8'h00, 17'h0, 17'h0);
    wait_take(3);
    cyc(1);
    chk({st.busy, req}, {8'h08, 8'h00}, "busy and acked");
    do_op(pic_pkg::RETURN_RELEASE_OP, 8'h00, 17'h0, 17'h0);
    chk(st.busy, 0, "release");
  endtask
  task automatic t_inhibit();
    pic_pkg::pic_op_e ops[4];
    ops = '{pic_pkg::REMOTE_RUN_OP, pic_pkg::CALL_SAVE_OP, pic_pkg::BRANCH_LINK_OP,
            pic_pkg::LEVEL_ARM_OP};
    do_op(pic_pkg::LEVEL_ARM_OP, 8'h80, 17'h0, 17'h0);
    foreach (ops[k]) begin
      intr_ok = 1'b0;
      req_up(8'h80, 6'h07);
      cyc(3);
      do_op(ops[k], 8'h80, 17'h0, 17'h0);
      intr_ok = 1'b1;
      t0 = takes;
      cyc(4);
      chk(takes - t0, 0, "no take after op");
      do_op(pic_pkg::OTHER_OP, 8'h00, 17'h0, 17'h0);
      wait_take(7);
      do_op(pic_pkg::RETURN_RELEASE_OP, 8'h00, 17'h0, 17'h0);
    end
  endtask
  task automatic t_ivec();
    req_up(8'h80, 6'h2d);
    wait_take(7);
    do_op(pic_pkg::INDIRECT_VECTOR_OP, 8'h00, 17'h15fff, 17'h0000c);
    chk(ivec_fetch, 0, "wrong location");
    do_op(pic_pkg::RETURN_RELEASE_OP, 8'h00, 17'h0, 17'h0);
    req_up(8'h80, 6'h2d);
    wait_take(7);
    do_op(pic_pkg::INDIRECT_VECTOR_OP, 8'h00, 17'h15fff, 17'h0000e);
    chk({ivec_fetch, ivec_addr}, {1'b1, 17'h15fed}, "vector fetch");
    do_op(pic_pkg::COUNT_INCREMENT_OP, 8'h00, 17'h0, 17'h0);
    chk(st.busy, 0, "auto clear");
  endtask
  task automatic t_prio();
    do_op(pic_pkg::LEVEL_ARM_OP, 8'hff, 17'h0, 17'h0);
    do_op(pic_pkg::OTHER_OP, 8'h00, 17'h0, 17'h0);
    req_up(8'h20, 6'h05);
    wait_take(5);
    cyc(1);
    t0 = takes;
    req_up(8'h40, 6'h06);
    cyc(6);
    chk(takes - t0, 0, "lower waits");
    req_up(8'h04, 6'h02);
    wait_take(2);
    cyc(1);
    chk(st.busy, 8'h24, "nested busy");
    do_op(pic_pkg::RETURN_RELEASE_OP, 8'h00, 17'h0, 17'h0);
    chk(st.busy, 8'h20, "inner released");
    do_op(pic_pkg::RETURN_RELEASE_OP, 8'h00, 17'h0, 17'h0);
    wait_take(6);
  endtask
  task automatic t_basic_reset();
    intr_ok = 1'b0;
    req_up(8'h08, 6'h13);
    cyc(3);
    do_op(pic_pkg::LEVEL_RESET_OP, 8'h48, 17'h0, 17'h0);
    chk((st.waiting | st.active | st.busy) & 8'h48, 0, "basic reset");
    chk(req[3], 1, "request kept");
    intr_ok = 1'b1;
    wait_take(3);
    do_op(pic_pkg::RETURN_RELEASE_OP, 8'h00, 17'h0, 17'h0);
  endtask
  task automatic t_full_reset();
    full_var = 1'b1;
    intr_ok = 1'b0;
    do_op(pic_pkg::LEVEL_DISARM_OP, 8'h10, 17'h0, 17'h0);
    req_up(8'h12, 6'h24);
    cyc(4);
    chk({st.waiting[4], st.active[1]}, 2'b11, "setup");
    do_op(pic_pkg::LEVEL_RESET_OP, 8'h10, 17'h0, 17'h0);
    chk(op_busy, 1, "sequence runs");
    for (int i = 0; i < 200 && op_busy !== 1'b0; i++) cyc(1);
    chk(req[4], 0, "controller cleared");
    chk(st.armed[4], 1, "rearmed");
    chk(st.active, 0, "all active cleared");
    do_op(pic_pkg::LEVEL_DISARM_OP, 8'h10, 17'h0, 17'h0);
    chk(st.armed[4], 0, "disarm after reset");
    do_op(pic_pkg::LEVEL_ARM_OP, 8'h10, 17'h0, 17'h0);
    chk({st.armed[4], st.waiting[4]}, 2'b10, "rearmed, nothing stale");
  endtask
  task automatic t_sys_reset();
    sys_reset = 1'b1;
    cyc(1);
    sys_reset = 1'b0;
    chk(dev_clear, 1, "device clear");
    cyc(1);
    chk({st.armed, st.waiting, st.active, st.busy, req}, 0, "system reset");
  endtask

  initial begin
    rst_b = 1'b0;
    {full_var, sys_reset, op_valid, instr_done, intr_ok} = 5'h00;
    op = '0;
    raise = 8'h00;
    unit = 6'h00;
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    cyc(1);
    chk({st, take, ivec_fetch, op_busy, ack}, 0, "after reset");
    t_arm();
    t_wait_arm();
    t_inhibit();
    t_ivec();
    t_prio();
    t_basic_reset();
    t_full_reset();
    t_sys_reset();
    conclude();
  end
  initial begin
    #(25 * 20000);
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
